// File: rtl/sodg_pkg.sv
// constants for the solenoid off-state diagnostic block
package sodg_pkg;
  localparam int CLK_MHZ = 100;
  // filter and update delay times in ns, min and max
  localparam int EN_FILT_MIN_NS = 1000;
  localparam int EN_FILT_MAX_NS = 2000;
  localparam int IN_FILT_MIN_NS = 1000;
  localparam int IN_FILT_MAX_NS = 2000;
  localparam int TON_FILT_MIN_NS = 3000;
  localparam int TON_FILT_MAX_NS = 4000;
  localparam int AVG_DLY_MIN_NS = 1000;
  localparam int AVG_DLY_MAX_NS = 5500;
  // cycle counts: least times round up
  localparam int EN_FILT_CYC = (EN_FILT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int IN_FILT_CYC = (IN_FILT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int TON_FILT_CYC = (TON_FILT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int AVG_DLY_CYC = (AVG_DLY_MIN_NS * CLK_MHZ + 999) / 1000;
  // blanking time per setting, in cycles
  localparam int BLANK_SEL_W = 2;
  localparam int BLANK_UNIT_NS = 10000;
  localparam int BLANK_UNIT_CYC = (BLANK_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  // flag positions in the fault vector
  localparam int FLAG_OPEN_LOAD = 0;
  localparam int FLAG_SHORT = 1;
  localparam int FLAG_DISCONNECT = 2;
  localparam int FLAG_W = 3;
  typedef enum logic [1:0] {
    SODG_ST_OFF = 2'b00,
    SODG_ST_ON = 2'b01,
    SODG_ST_BLANK = 2'b10,
    SODG_ST_DIAG = 2'b11
  } sodg_state_t;
endpackage

// File: rtl/sodg_filter.sv
// deglitch filter: level accepted after stable for a count of cycles
`timescale 1ns/1ps
module sodg_filter #(
  parameter int CYCLES = 100
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;
  wire differ = din != dout;
  wire done = cnt_r == W'(CYCLES - 1);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      dout <= 1'b0;
    end else if (!differ) begin
      cnt_r <= '0;
    end else if (done) begin
      cnt_r <= '0;
      dout <= din;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end
endmodule

// File: rtl/sodg_core.sv
// one solenoid channel: disconnect fault, off-state diag, input filters
`timescale 1ns/1ps
module sodg_core #(
  parameter int BLANK_UNIT = sodg_pkg::BLANK_UNIT_CYC,
  parameter int AVG_DLY = sodg_pkg::AVG_DLY_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic driver_global_enable_pin,
  input wire logic channel_command_input,
  input wire logic channel_enable,
  input wire logic high_side_select,
  input wire logic software_control_select,
  input wire logic diag_enable,
  input wire logic [sodg_pkg::BLANK_SEL_W-1:0] blank_sel,
  input wire logic clamp_active,
  input wire logic battery_overvoltage,
  input wire logic open_load_comparator,
  input wire logic low_voltage_comparator,
  input wire logic fault_read,
  output logic channel_on,
  output logic tristate,
  output logic diag_pull_enable,
  output logic [sodg_pkg::FLAG_W-1:0] fault_flags,
  output logic global_enable_filtered,
  output logic command_filtered,
  output logic avg_update,
  output logic drive_on
);
  sodg_pkg::sodg_state_t st_r, st_nxt;
  logic [sodg_pkg::CNT_W-1:0] blank_cnt_r;
  logic [sodg_pkg::CNT_W-1:0] avg_cnt_r;
  logic [sodg_pkg::CNT_W-1:0] ton_cnt_r;
  logic en_flt, cmd_flt, cmd_prev_r, avg_pend_r;

  function automatic logic [1:0] decode(input logic hs, input logic ol,
                                        input logic lv);
    logic [1:0] f;
    f = 2'b00;
    if (ol && !lv) begin
      f[sodg_pkg::FLAG_OPEN_LOAD] = 1'b1;
    end else if (!hs && ol && lv) begin
      f[sodg_pkg::FLAG_SHORT] = 1'b1;
    end else if (hs && !ol && !lv) begin
      f[sodg_pkg::FLAG_SHORT] = 1'b1;
    end
    return f;
  endfunction

  // filters
  sodg_filter #(.CYCLES(sodg_pkg::EN_FILT_CYC)) u_en_flt (
    .mclk(mclk),
    .rst(rst),
    .din(driver_global_enable_pin),
    .dout(en_flt)
  );
  sodg_filter #(.CYCLES(sodg_pkg::IN_FILT_CYC)) u_cmd_flt (
    .mclk(mclk),
    .rst(rst),
    .din(channel_command_input),
    .dout(cmd_flt)
  );

  // clamp event, masked during overvoltage
  wire clamp_fault = clamp_active && !battery_overvoltage &&
                     st_r == sodg_pkg::SODG_ST_ON;
  wire disc_set = fault_flags[sodg_pkg::FLAG_DISCONNECT];
  // enable ignores off-state flags, only the disconnect flag blocks
  wire en_req = channel_enable && en_flt && !disc_set &&
                !clamp_fault;
  wire [sodg_pkg::CNT_W-1:0] blank_len =
    sodg_pkg::CNT_W'(BLANK_UNIT * (32'(blank_sel) + 1));
  wire diag_live = st_r == sodg_pkg::SODG_ST_DIAG && diag_enable;
  wire [1:0] dec = decode(high_side_select, open_load_comparator,
                          low_voltage_comparator);
  wire [1:0] diag_set = diag_live ? dec : 2'b00;
  wire [sodg_pkg::FLAG_W-1:0] set_vec = {clamp_fault, diag_set};
  // set wins over read clear
  wire [sodg_pkg::FLAG_W-1:0] flags_nxt =
    (fault_read ? '0 : fault_flags) | set_vec;
  wire cmd_edge = cmd_flt != cmd_prev_r;
  wire sw_drive = software_control_select && cmd_flt &&
                  st_r == sodg_pkg::SODG_ST_ON;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sodg_pkg::SODG_ST_OFF: begin
        if (en_req) begin
          st_nxt = sodg_pkg::SODG_ST_ON;
        end else begin
          st_nxt = sodg_pkg::SODG_ST_BLANK;
        end
      end
      sodg_pkg::SODG_ST_ON: begin
        if (clamp_fault || !channel_enable || !en_flt) begin
          st_nxt = sodg_pkg::SODG_ST_BLANK;
        end
      end
      sodg_pkg::SODG_ST_BLANK: begin
        if (en_req) begin
          st_nxt = sodg_pkg::SODG_ST_ON;
        end else if (blank_cnt_r >= blank_len - 1'b1) begin
          st_nxt = sodg_pkg::SODG_ST_DIAG;
        end
      end
      sodg_pkg::SODG_ST_DIAG: begin
        if (en_req) begin
          st_nxt = sodg_pkg::SODG_ST_ON;
        end
      end
      default: st_nxt = sodg_pkg::SODG_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= sodg_pkg::SODG_ST_OFF;
      blank_cnt_r <= '0;
      fault_flags <= '0;
    end else begin
      st_r <= st_nxt;
      fault_flags <= flags_nxt;
      if (st_r == sodg_pkg::SODG_ST_BLANK) begin
        blank_cnt_r <= blank_cnt_r + 1'b1;
      end else begin
        blank_cnt_r <= '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_on <= 1'b0;
      tristate <= 1'b1;
      diag_pull_enable <= 1'b0;
      global_enable_filtered <= 1'b0;
      command_filtered <= 1'b0;
    end else begin
      channel_on <= st_nxt == sodg_pkg::SODG_ST_ON;
      tristate <= st_nxt != sodg_pkg::SODG_ST_ON;
      diag_pull_enable <= diag_enable &&
                          st_nxt != sodg_pkg::SODG_ST_ON;
      global_enable_filtered <= en_flt;
      command_filtered <= cmd_flt;
    end
  end

  // average current update follows filtered command edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_prev_r <= 1'b0;
      avg_pend_r <= 1'b0;
      avg_cnt_r <= '0;
      avg_update <= 1'b0;
    end else begin
      cmd_prev_r <= cmd_flt;
      avg_update <= 1'b0;
      if (software_control_select && cmd_edge) begin
        avg_pend_r <= 1'b1;
        avg_cnt_r <= '0;
      end else if (avg_pend_r) begin
        if (avg_cnt_r == sodg_pkg::CNT_W'(AVG_DLY - 1)) begin
          avg_pend_r <= 1'b0;
          avg_update <= 1'b1;
        end else begin
          avg_cnt_r <= avg_cnt_r + 1'b1;
        end
      end
    end
  end

  // turn-on filter on the load drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ton_cnt_r <= '0;
      drive_on <= 1'b0;
    end else if (!sw_drive) begin
      ton_cnt_r <= '0;
      drive_on <= 1'b0;
    end else if (ton_cnt_r ==
                 sodg_pkg::CNT_W'(sodg_pkg::TON_FILT_CYC - 1)) begin
      drive_on <= 1'b1;
    end else begin
      ton_cnt_r <= ton_cnt_r + 1'b1;
    end
  end
endmodule

// File: testbench/sodg_mcu.sv
// controller model: channel enable, diag enable, fault read
`timescale 1ns/1ps
module sodg_mcu (
  input wire logic mclk,
  output logic channel_enable,
  output logic diag_enable,
  output logic fault_read
);
  initial {channel_enable, diag_enable, fault_read} = 3'h0;
  task automatic en(input logic v);
    @(negedge mclk) channel_enable = v;
  endtask
  task automatic dg(input logic v);
    @(negedge mclk) diag_enable = v;
  endtask
  task automatic rd();
    @(negedge mclk) fault_read = 1'b1;
    @(negedge mclk) fault_read = 1'b0;
  endtask
endmodule

// File: testbench/sodg_chk.sv
// assertions on the channel ports
`timescale 1ns/1ps
module sodg_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic high_side_select,
  input wire logic software_control_select,
  input wire logic clamp_active,
  input wire logic battery_overvoltage,
  input wire logic open_load_comparator,
  input wire logic low_voltage_comparator,
  input wire logic fault_read,
  input wire logic channel_on,
  input wire logic tristate,
  input wire logic [sodg_pkg::FLAG_W-1:0] fault_flags,
  input wire logic command_filtered,
  input wire logic avg_update
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_clamp; channel_on && clamp_active && !battery_overvoltage
    |-> ##[1:2] fault_flags[2] && tristate; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  property p_lock; fault_flags[2] |=> !channel_on; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_clr; fault_read && channel_on && !clamp_active
    |=> fault_flags == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_blank; $rose(tristate)
    |=> (!$rose(fault_flags[0]) && !$rose(fault_flags[1])) [*4]; endproperty
  a_blank: assert property (p_blank) else $error("blank");
  property p_ls; $rose(fault_flags[1]) && !high_side_select
    |-> $past(open_load_comparator) && $past(low_voltage_comparator);
  endproperty
  a_ls: assert property (p_ls) else $error("ls");
  property p_hs; $rose(fault_flags[1]) && high_side_select
    |-> !$past(open_load_comparator) && !$past(low_voltage_comparator);
  endproperty
  a_hs: assert property (p_hs) else $error("hs");
  property p_ol; $rose(fault_flags[0])
    |-> $past(open_load_comparator) && !$past(low_voltage_comparator);
  endproperty
  a_ol: assert property (p_ol) else $error("ol");
  property p_avg; software_control_select && $changed(command_filtered)
    |-> ##[4:20] avg_update;
  endproperty
  a_avg: assert property (p_avg) else $error("avg");
  c_dis: cover property ($rose(fault_flags[2]));
  c_ol: cover property ($rose(fault_flags[0]));
  c_avg: cover property (avg_update);
endmodule
bind sodg_core sodg_chk u_chk (.*);

// File: testbench/testbench.sv
// bench for the solenoid off-state diagnostic channel
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
`define WT(c) begin i = 0; while (!(c) && i < 500) begin @(negedge mclk); \
  i++; end if (!(c)) begin err_count++; give_verdict(); end end
module testbench;
  logic mclk, rst, gen, cmd, hs, ovl, clamp, ol, lv, ch_en, dg_en, frd, sw;
  logic on, tri_s, pull, gen_f, cmd_f, avg, drv;
  logic [1:0] bsel;
  logic [sodg_pkg::FLAG_W-1:0] flags;
  logic [1:0] dx [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
  int err_count = 0, n_tests = 0, i;
  sodg_mcu u_mcu (.mclk(mclk), .channel_enable(ch_en),
    .diag_enable(dg_en), .fault_read(frd));
  sodg_core #(.BLANK_UNIT(4), .AVG_DLY(4)) u_dut (.mclk(mclk), .rst(rst),
    .driver_global_enable_pin(gen), .channel_command_input(cmd),
    .channel_enable(ch_en), .high_side_select(hs),
    .software_control_select(sw), .diag_enable(dg_en), .blank_sel(bsel),
    .clamp_active(clamp), .battery_overvoltage(ovl),
    .open_load_comparator(ol), .low_voltage_comparator(lv),
    .fault_read(frd), .channel_on(on), .tristate(tri_s),
    .diag_pull_enable(pull), .fault_flags(flags),
    .global_enable_filtered(gen_f), .command_filtered(cmd_f),
    .avg_update(avg), .drive_on(drv));
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_enable();
    @(negedge mclk) gen = 1'b1;
    u_mcu.en(1'b1);
    repeat (90) @(negedge mclk);
    `CHK("early", 1'b0, on)
    `CHK("genf0", 1'b0, gen_f)
    `WT(on)
    `CHK("genf", 1'b1, gen_f)
    `CHK("tri", 1'b0, tri_s)
  endtask
  task automatic t_clamp();
    @(negedge mclk) {ovl, clamp} = 2'h3;
    @(negedge mclk) clamp = 1'b0;
    @(negedge mclk) ovl = 1'b0;
    `CHK("ovmask", 2'h2, {on, flags[2]})
    @(negedge mclk) clamp = 1'b1;
    @(negedge mclk) clamp = 1'b0;
    repeat (20) @(negedge mclk);
    `CHK("clamp", 3'h5, {tri_s, on, flags[2]})
    u_mcu.rd();
    u_mcu.en(1'b1);
    `WT(on)
    `CHK("restart", 1'b0, flags[2])
  endtask
  task automatic t_cmd();
    @(negedge mclk) cmd = 1'b1;
    repeat (90) @(negedge mclk);
    `CHK("cmd", 1'b0, cmd_f)
    `WT(cmd_f)
    `CHK("avg0", 1'b0, avg)
    repeat (4) @(negedge mclk);
    `CHK("avg", 1'b1, avg)
    repeat (286) @(negedge mclk);
    `CHK("ton", 1'b0, drv)
    `WT(drv)
    cmd = 1'b0;
    `WT(!cmd_f)
  endtask
  task automatic t_swoff();
    @(negedge mclk) {sw, cmd} = 2'h1;
    `WT(cmd_f)
    repeat (310) @(negedge mclk);
    `CHK("swoff", 1'b0, drv)
    {sw, cmd} = 2'h2;
    `WT(!cmd_f)
  endtask
  task automatic t_diag(input logic h, input logic [1:0] c,
    input logic [1:0] e);
    @(negedge mclk) {hs, ol, lv, bsel} = {h, c, 1'b0, h};
    u_mcu.en(1'b0);
    u_mcu.dg(1'b1);
    repeat (2) @(negedge mclk);
    `CHK("blank", 2'h0, flags[1:0])
    repeat (4) @(negedge mclk);
    `CHK("blank2", h ? 2'h0 : e, flags[1:0])
    repeat (16) @(negedge mclk);
    `CHK("decode", e, flags[1:0])
    u_mcu.en(1'b1);
    `WT(on)
    `CHK("pull", 1'b0, pull)
    u_mcu.rd();
    @(negedge mclk);
    `CHK("clear", 2'h0, flags[1:0])
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    {gen, cmd, hs, ovl, clamp, ol, lv} = 7'h00;
    sw = 1'b1;
    bsel = 2'h0;
    repeat (5) @(negedge mclk);
    `CHK("reset", 6'h20, {tri_s, on, pull, flags})
    rst = 1'b0;
    t_enable();
    t_clamp();
    t_cmd();
    t_swoff();
    for (int k = 0; k < 8; k++) t_diag(k[2], k[1:0], dx[k]);
    give_verdict();
  end
endmodule
